// ---- design/pfs_top.sv ----
// pad function select: per-pad output mux, input gating and defaults
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: select 00..11 picks function 0..3
// RULE2: select field steers only the output path
// RULE3: input reaches peripheral only when buffer enabled
// RULE4: reset configuration applies during and after reset; pad outputs stay undriven and slow until the first edge after reset
// RULE5: nmi selection overrides the select field
// RULE6: pads reset to port mode, tap pads excepted
// RULE7: tap pads carry data in, out, clock, mode
// RULE8: software alone moves tap pads to port use
// RULE9: tap output pad resets function 2, medium speed
// RULE10: output enable bit matters only in port mode
// RULE11: software keeps input enable clear where restricted
// RULE12: wake pads also feed external interrupts
// RULE13: boot-only functions work only while booting
// RULE14: pad class limits speed and output functions
// RULE15: writes reach the pad one edge later
module pfs_top
  import pfs_pkg::*;
#(
  parameter int NUM_PADS = PFS_NUM_PADS,
  parameter pfs_class_t [NUM_PADS-1:0] PAD_CLASS = PFS_DEF_CLASS,
  parameter logic [4*NUM_PADS-1:0] FUNC_MASK = PFS_DEF_FUNC_MASK,
  parameter logic [NUM_PADS-1:0] WAKE_MASK = PFS_DEF_WAKE_MASK,
  parameter logic [NUM_PADS-1:0] BOOT_MASK = PFS_DEF_BOOT_MASK,
  parameter logic [NUM_PADS-1:0] NMI_MASK = PFS_DEF_NMI_MASK,
  localparam int IDXW = $clog2(NUM_PADS)
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // configuration access
  input wire logic cfg_wr_in,
  input wire logic [IDXW-1:0] cfg_idx_in,
  input wire pfs_cfg_t cfg_wdata_in,
  input wire logic [IDXW-1:0] cfg_rd_idx_in,
  output pfs_cfg_t cfg_rdata_out,
  // boot path
  input wire logic boot_phase_in,
  input wire pfs_drive_t [NUM_PADS-1:0] boot_drive_in,
  // peripheral output functions
  input wire pfs_func_t [NUM_PADS-1:0] func_in,
  // pads
  input wire logic [NUM_PADS-1:0] pad_level_in,
  output pfs_drive_t [NUM_PADS-1:0] pad_drive_out,
  output pfs_speed_t [NUM_PADS-1:0] pad_speed_out,
  // peripheral inputs and interrupts
  output logic [NUM_PADS-1:0] periph_level_out,
  output logic [NUM_PADS-1:0] wake_irq_out,
  output logic nmi_out
);

  if (NUM_PADS < PFS_NUM_TAP_PADS || NUM_PADS > PFS_MAX_PADS) begin : g_chk
    $error("pfs_top: NUM_PADS out of range");
  end

  logic [NUM_PADS-1:0] pad_sync;
  pfs_cfg_t [NUM_PADS-1:0] cfg;
  logic [NUM_PADS-1:0] nmi_lvl;
  logic next_nmi;
  pfs_cfg_t next_rdata;
  logic first_cyc;
  logic next_first;

  // pins are asynchronous to mclk_in
  pfs_sync2 #(
    .WIDTH(NUM_PADS)
  ) u_sync (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .d_in(pad_level_in),
    .q_out(pad_sync)
  );

  for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
    localparam pfs_cfg_t RST_CFG =
      (i == PFS_PAD_TDO) ? PFS_RST_TAP_OUT :
      (i == PFS_PAD_TDI || i == PFS_PAD_TCK || i == PFS_PAD_TMS) ?
      PFS_RST_TAP_IN : PFS_RST_GPIO;
    logic [PFS_NUM_FUNCS-1:0] avail;
    logic boot_act;
    logic nmi_act;
    pfs_drive_t next_drive;
    pfs_drive_t drive;
    pfs_speed_t next_speed;
    pfs_speed_t speed;
    logic next_level;
    logic next_wake;
    logic next_nmi_lvl;

    pfs_cfg_slot #(
      .RST_CFG(RST_CFG) // RULE6
    ) u_slot (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .wr_en_in(cfg_wr_in && cfg_idx_in == IDXW'(i)),
      .wdata_in(cfg_wdata_in),
      .cfg_out(cfg[i])
    );

    always_comb begin
      avail = FUNC_MASK[4*i +: 4];
      if (PAD_CLASS[i] == PFS_CLS_I) begin
        avail = 4'h0; // RULE14
      end else if (PAD_CLASS[i] == PFS_CLS_J) begin
        avail = avail & 4'h1; // RULE14
      end
      boot_act = boot_phase_in && BOOT_MASK[i];
      nmi_act = cfg[i].nmi_select && NMI_MASK[i];
      // boot drive only exists while booting; no select code reaches it
      if (boot_act) begin
        next_drive = boot_drive_in[i]; // RULE13
      end else if (nmi_act) begin
        next_drive = '0; // RULE5
      end else if (cfg[i].alt_func_select == PFS_AF_0) begin
        next_drive.dout = func_in[i].dout[0]; // RULE1
        next_drive.oe = cfg[i].output_buffer_enable & avail[0]; // RULE10
      end else begin
        // tap output on function 2 brings its own enable
        next_drive.dout = func_in[i].dout[cfg[i].alt_func_select]; // RULE1 RULE7
        next_drive.oe = func_in[i].oe[cfg[i].alt_func_select] &
                        avail[cfg[i].alt_func_select]; // RULE10
      end
      if (PAD_CLASS[i] == PFS_CLS_I) begin
        next_drive.oe = 1'b0; // RULE14
      end
      case (PAD_CLASS[i])
        PFS_CLS_F: begin
          next_speed = (cfg[i].speed == PFS_SPD_SLOW) ? PFS_SPD_SLOW :
                       (cfg[i].speed == PFS_SPD_MEDIUM) ? PFS_SPD_MEDIUM :
                       PFS_SPD_FAST; // RULE9
        end
        PFS_CLS_M: begin
          next_speed = (cfg[i].speed == PFS_SPD_SLOW) ? PFS_SPD_SLOW :
                       PFS_SPD_MEDIUM; // RULE14
        end
        default: begin
          next_speed = PFS_SPD_SLOW; // RULE14
        end
      endcase
      // input gating ignores the select field entirely
      next_level = pad_sync[i] & cfg[i].input_buffer_enable; // RULE2 RULE3
      next_wake = next_level & WAKE_MASK[i]; // RULE12
      next_nmi_lvl = pad_sync[i] & nmi_act; // RULE5
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        drive <= '0;
        speed <= PFS_SPD_SLOW;
        periph_level_out[i] <= 1'b0;
        wake_irq_out[i] <= 1'b0;
        nmi_lvl[i] <= 1'b0;
      end else begin
        drive <= next_drive; // RULE15
        speed <= next_speed;
        periph_level_out[i] <= next_level;
        wake_irq_out[i] <= next_wake;
        nmi_lvl[i] <= next_nmi_lvl;
      end
    end

    assign pad_drive_out[i] = drive;
    assign pad_speed_out[i] = speed;
  end

  always_comb begin
    next_nmi = |nmi_lvl; // RULE5
    next_first = 1'b0;
    next_rdata = '0;
    if (32'(cfg_rd_idx_in) < NUM_PADS) begin
      next_rdata = cfg[cfg_rd_idx_in];
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nmi_out <= 1'b0;
      cfg_rdata_out <= '0;
      first_cyc <= 1'b1;
    end else begin
      nmi_out <= next_nmi;
      cfg_rdata_out <= next_rdata;
      first_cyc <= next_first;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  tap_reset_cfg_a: assert property ( // RULE6 RULE7 RULE9
    first_cyc |-> cfg[PFS_PAD_TDO].alt_func_select == PFS_AF_2 &&
      cfg[PFS_PAD_TDO].speed == PFS_SPD_MEDIUM &&
      cfg[PFS_PAD_TDO].output_buffer_enable &&
      cfg[PFS_PAD_TDI].input_buffer_enable &&
      cfg[PFS_PAD_TCK].input_buffer_enable &&
      cfg[PFS_PAD_TMS].input_buffer_enable)
    else $error("tap pads not in reset configuration");

  nmi_collect_a: assert property ( // RULE5
    |nmi_lvl |=> nmi_out)
    else $error("nmi level lost");

  // first_cyc marks the first edge out of reset, so defaults are seen once
  tap_speed_a: assert property ( // RULE9
    first_cyc && PAD_CLASS[PFS_PAD_TDO] inside {PFS_CLS_F, PFS_CLS_M}
    |=> pad_speed_out[PFS_PAD_TDO] == PFS_SPD_MEDIUM)
    else $error("tap output pad not at medium speed");

  rdata_track_a: assert property ( // RULE4
    32'(cfg_rd_idx_in) < NUM_PADS |=> cfg_rdata_out == $past(cfg[cfg_rd_idx_in]))
    else $error("read back config wrong");

  for (genvar i = 0; i < NUM_PADS; i++) begin : g_chk_pad
    // steps shared by the per-pad checks
    sequence s_write;
      cfg_wr_in && cfg_idx_in == IDXW'(i);
    endsequence
    sequence s_plain_path;
      !(boot_phase_in && BOOT_MASK[i]) && !(cfg[i].nmi_select && NMI_MASK[i]);
    endsequence
    sequence s_alt_path;
      s_plain_path ##0 (cfg[i].alt_func_select != PFS_AF_0 && PAD_CLASS[i] != PFS_CLS_I);
    endsequence
    sequence s_nmi_seen;
      cfg[i].nmi_select && NMI_MASK[i] && pad_sync[i];
    endsequence

    write_reach_a: assert property ( // RULE15
      s_write ##1 (s_plain_path and
        cfg[i].alt_func_select == PFS_AF_0 && PAD_CLASS[i] != PFS_CLS_I)
      |=> pad_drive_out[i].oe == ($past(cfg_wdata_in.output_buffer_enable, 2) &
          FUNC_MASK[4*i]))
      else $error("config write did not reach pad");

    cfg_hold_a: assert property ( // RULE4 RULE8
      !(cfg_wr_in && cfg_idx_in == IDXW'(i)) |=> $stable(cfg[i]))
      else $error("config changed without write");

    input_gate_a: assert property ( // RULE3
      cfg[i].input_buffer_enable |=> periph_level_out[i] == $past(pad_sync[i]))
      else $error("enabled input not passed");

    input_block_a: assert property ( // RULE2 RULE3
      !cfg[i].input_buffer_enable |=> !periph_level_out[i] && !wake_irq_out[i])
      else $error("disabled input leaked");

    nmi_override_a: assert property ( // RULE5
      cfg[i].nmi_select && NMI_MASK[i] && !(boot_phase_in && BOOT_MASK[i])
      |=> !pad_drive_out[i].oe)
      else $error("nmi pad driven");

    port_drive_a: assert property ( // RULE10
      s_plain_path ##0 (cfg[i].alt_func_select == PFS_AF_0 && PAD_CLASS[i] != PFS_CLS_I)
      |=> pad_drive_out[i].oe == ($past(cfg[i].output_buffer_enable) && FUNC_MASK[4*i]) &&
          pad_drive_out[i].dout == $past(func_in[i].dout[0]))
      else $error("port path drive wrong");

    alt_enable_a: assert property ( // RULE1 RULE14
      s_alt_path |=> pad_drive_out[i].oe == (PAD_CLASS[i] != PFS_CLS_J &&
        $past(func_in[i].oe[cfg[i].alt_func_select]) &&
        FUNC_MASK[4*i + 32'($past(cfg[i].alt_func_select))]))
      else $error("alternate function enable wrong");

    boot_drive_a: assert property ( // RULE13
      boot_phase_in && BOOT_MASK[i] && PAD_CLASS[i] != PFS_CLS_I
      |=> pad_drive_out[i] == $past(boot_drive_in[i]))
      else $error("boot drive not on pad");

    nmi_path_a: assert property ( // RULE5
      s_nmi_seen |-> ##2 nmi_out)
      else $error("nmi pad level not forwarded");

    speed_fast_a: assert property ( // RULE14
      PAD_CLASS[i] == PFS_CLS_F && cfg[i].speed[1] |=> pad_speed_out[i] == PFS_SPD_FAST)
      else $error("fast pad not fast");

    func_drive_a: assert property ( // RULE1 RULE10
      s_plain_path and cfg[i].alt_func_select != PFS_AF_0
      |=> pad_drive_out[i].dout ==
          $past(func_in[i].dout[cfg[i].alt_func_select]))
      else $error("wrong function on pad");

    wake_irq_a: assert property ( // RULE12
      WAKE_MASK[i] && cfg[i].input_buffer_enable && pad_sync[i]
      |=> wake_irq_out[i])
      else $error("wake level not forwarded");

    boot_only_a: assert property ( // RULE13
      !(boot_phase_in && BOOT_MASK[i]) && PAD_CLASS[i] != PFS_CLS_I
      ##1 !(boot_phase_in && BOOT_MASK[i])
      |-> !pad_drive_out[i].oe || !$past(boot_drive_in[i].oe) ||
          $past(cfg[i].alt_func_select) != PFS_AF_0 ||
          $past(cfg[i].output_buffer_enable))
      else $error("boot drive outside boot phase");

    class_limit_a: assert property ( // RULE14
      PAD_CLASS[i] != PFS_CLS_F |-> pad_speed_out[i] != PFS_SPD_FAST &&
        (PAD_CLASS[i] == PFS_CLS_M || pad_speed_out[i] == PFS_SPD_SLOW) &&
        (PAD_CLASS[i] != PFS_CLS_I || !pad_drive_out[i].oe))
      else $error("pad class limit broken");
  end

endmodule : pfs_top
`default_nettype wire

// ---- design/pfs_pkg.sv ----
// shared types and constants for the pad function select block
package pfs_pkg;

  localparam int PFS_NUM_PADS = 8;
  localparam int PFS_NUM_FUNCS = 4;
  localparam int PFS_MAX_PADS = 256;

  // pads carrying the test access port out of reset
  localparam int PFS_PAD_TDI = 0;
  localparam int PFS_PAD_TDO = 1;
  localparam int PFS_PAD_TCK = 2;
  localparam int PFS_PAD_TMS = 3;
  localparam int PFS_NUM_TAP_PADS = 4;

  // function choice field codes
  localparam logic [1:0] PFS_AF_0 = 2'h0;
  localparam logic [1:0] PFS_AF_1 = 2'h1;
  localparam logic [1:0] PFS_AF_2 = 2'h2;
  localparam logic [1:0] PFS_AF_3 = 2'h3;

  typedef logic [1:0] pfs_speed_t;
  localparam pfs_speed_t PFS_SPD_SLOW = 2'h0;
  localparam pfs_speed_t PFS_SPD_MEDIUM = 2'h1;
  localparam pfs_speed_t PFS_SPD_FAST = 2'h2;

  typedef enum logic [2:0] {
    PFS_CLS_F,
    PFS_CLS_M,
    PFS_CLS_S,
    PFS_CLS_I,
    PFS_CLS_J
  } pfs_class_t;

  typedef struct packed {
    logic nmi_select;
    logic input_buffer_enable;
    logic output_buffer_enable;
    pfs_speed_t speed;
    logic [1:0] alt_func_select;
  } pfs_cfg_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } pfs_drive_t;

  typedef struct packed {
    logic [PFS_NUM_FUNCS-1:0] dout;
    logic [PFS_NUM_FUNCS-1:0] oe;
  } pfs_func_t;

  // reset configurations: plain port pad tristated, tap inputs, tap output
  localparam pfs_cfg_t PFS_RST_GPIO = '{1'b0, 1'b0, 1'b0, PFS_SPD_SLOW, PFS_AF_0};
  localparam pfs_cfg_t PFS_RST_TAP_IN = '{1'b0, 1'b1, 1'b0, PFS_SPD_SLOW, PFS_AF_0};
  localparam pfs_cfg_t PFS_RST_TAP_OUT = '{1'b0, 1'b0, 1'b1, PFS_SPD_MEDIUM, PFS_AF_2};

  // default pad set
  localparam pfs_class_t [PFS_NUM_PADS-1:0] PFS_DEF_CLASS = '{
    PFS_CLS_I, PFS_CLS_J, PFS_CLS_M, PFS_CLS_S,
    PFS_CLS_S, PFS_CLS_S, PFS_CLS_F, PFS_CLS_M};
  localparam logic [4*PFS_NUM_PADS-1:0] PFS_DEF_FUNC_MASK = 32'h1f3f_7f7f;
  localparam logic [PFS_NUM_PADS-1:0] PFS_DEF_WAKE_MASK = 8'h30;
  localparam logic [PFS_NUM_PADS-1:0] PFS_DEF_BOOT_MASK = 8'h40;
  localparam logic [PFS_NUM_PADS-1:0] PFS_DEF_NMI_MASK = 8'h10;

endpackage : pfs_pkg

// ---- design/pfs_sync2.sv ----
// two-stage synchroniser for pad levels
`timescale 1ns/1ps
`default_nettype none
module pfs_sync2 #(
  parameter int WIDTH = 1
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // levels
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule : pfs_sync2
`default_nettype wire

// ---- design/pfs_cfg_slot.sv ----
// one pad configuration register with its own reset value
`timescale 1ns/1ps
`default_nettype none
module pfs_cfg_slot
  import pfs_pkg::*;
#(
  parameter pfs_cfg_t RST_CFG = PFS_RST_GPIO
)(
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // write port
  input wire logic wr_en_in,
  input wire pfs_cfg_t wdata_in,
  output pfs_cfg_t cfg_out
);

  pfs_cfg_t next_cfg;

  // only a write or reset changes the value; nothing else moves it
  always_comb begin
    next_cfg = cfg_out;
    if (wr_en_in) begin
      next_cfg = wdata_in; // RULE15
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_out <= RST_CFG; // RULE4
    end else begin
      cfg_out <= next_cfg; // RULE8
    end
  end

endmodule : pfs_cfg_slot
`default_nettype wire

// ---- test/pfs_pad_model.sv ----
// board side of the pads: resolves each pad wire
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model
  import pfs_pkg::*;
#(
  parameter int NUM_PADS = PFS_NUM_PADS
)(
  // device drivers
  input wire pfs_drive_t [NUM_PADS-1:0] pad_drive_in,
  // board levels
  input wire logic [NUM_PADS-1:0] board_level_in,
  output logic [NUM_PADS-1:0] pad_level_out
);
  // an undriven pad shows the board level, never the last driven value
  always_comb begin
    for (int k = 0; k < NUM_PADS; k++) begin
      pad_level_out[k] = pad_drive_in[k].oe ? pad_drive_in[k].dout : board_level_in[k];
    end
  end
endmodule : pfs_pad_model
`default_nettype wire

// ---- test/pfs_top_tb.sv ----
// self-checking bench for the pad function select block
`timescale 1ns/1ps
`default_nettype none
module pfs_top_tb;
  import pfs_pkg::*;
  localparam int N = PFS_NUM_PADS;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic [2:0] cfg_idx_in = 3'h0;
  pfs_cfg_t cfg_wdata_in = '0;
  logic [2:0] cfg_rd_idx_in = 3'h0;
  pfs_cfg_t cfg_rdata_out;
  logic boot_phase_in = 1'b0;
  pfs_drive_t [N-1:0] boot_drive_in = '0;
  pfs_func_t [N-1:0] func_in = '0;
  logic [N-1:0] board_lvl = '0;
  logic [N-1:0] pad_level_in;
  pfs_drive_t [N-1:0] pad_drive_out;
  pfs_speed_t [N-1:0] pad_speed_out;
  logic [N-1:0] periph_level_out;
  logic [N-1:0] wake_irq_out;
  logic nmi_out;
  pfs_cfg_t sh [N];
  int mismatches = 0;
  int samples_checked = 0;

  always #25 mclk_in = ~mclk_in;

  pfs_top dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .cfg_wr_in(cfg_wr_in),
    .cfg_idx_in(cfg_idx_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rd_idx_in(cfg_rd_idx_in),
    .cfg_rdata_out(cfg_rdata_out), .boot_phase_in(boot_phase_in),
    .boot_drive_in(boot_drive_in), .func_in(func_in), .pad_level_in(pad_level_in),
    .pad_drive_out(pad_drive_out), .pad_speed_out(pad_speed_out),
    .periph_level_out(periph_level_out), .wake_irq_out(wake_irq_out), .nmi_out(nmi_out)
  );

  pfs_pad_model #(.NUM_PADS(N)) pads (
    .pad_drive_in(pad_drive_out), .board_level_in(board_lvl), .pad_level_out(pad_level_in)
  );

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic pfs_cfg_t rst_cfg(input int k);
    if (k == PFS_PAD_TDO) return PFS_RST_TAP_OUT;
    if (k <= PFS_PAD_TMS) return PFS_RST_TAP_IN;
    return PFS_RST_GPIO;
  endfunction : rst_cfg

  // the boot pad carries an input function whose input enable must stay clear
  localparam logic [N-1:0] NO_IBE_MASK = 8'h40;

  function automatic pfs_cfg_t rnd_cfg(input int k);
    pfs_cfg_t c;
    c = 7'($urandom);
    if (NO_IBE_MASK[k]) c.input_buffer_enable = 1'b0;
    return c;
  endfunction : rnd_cfg

  function automatic pfs_drive_t exp_drive(input int k);
    logic [3:0] m;
    logic [1:0] a;
    pfs_drive_t d;
    m = PFS_DEF_FUNC_MASK[4*k +: 4];
    a = sh[k].alt_func_select;
    // analog pads keep only the port path, input-only pads never drive
    if (PFS_DEF_CLASS[k] == PFS_CLS_J) m = m & 4'h1;
    if (PFS_DEF_CLASS[k] == PFS_CLS_I) m = 4'h0;
    d.dout = func_in[k].dout[a];
    d.oe = (a == PFS_AF_0) ? sh[k].output_buffer_enable & m[0] : func_in[k].oe[a] & m[a];
    if (sh[k].nmi_select && PFS_DEF_NMI_MASK[k]) d = '0;
    if (boot_phase_in && PFS_DEF_BOOT_MASK[k]) d = boot_drive_in[k];
    return d;
  endfunction : exp_drive

  function automatic pfs_speed_t exp_speed(input int k);
    case (PFS_DEF_CLASS[k])
      PFS_CLS_F: return sh[k].speed[1] ? PFS_SPD_FAST : sh[k].speed;
      PFS_CLS_M: return (sh[k].speed == PFS_SPD_SLOW) ? PFS_SPD_SLOW : PFS_SPD_MEDIUM;
      default: return PFS_SPD_SLOW;
    endcase
  endfunction : exp_speed

  task automatic check_all();
    pfs_drive_t e;
    logic [N-1:0] lv;
    logic nm;
    #1;
    nm = 1'b0;
    for (int k = 0; k < N; k++) begin
      e = exp_drive(k);
      lv[k] = e.oe ? e.dout : board_lvl[k];
      nm = nm | (lv[k] & sh[k].nmi_select & PFS_DEF_NMI_MASK[k]);
      chk(8'(pad_drive_out[k].oe), 8'(e.oe), "oe");
      if (e.oe) chk(8'(pad_drive_out[k].dout), 8'(e.dout), "dout");
      chk(8'(pad_speed_out[k]), 8'(exp_speed(k)), "speed");
      chk(8'(periph_level_out[k]), 8'(lv[k] & sh[k].input_buffer_enable), "in");
      chk(8'(wake_irq_out[k]), 8'(lv[k] & sh[k].input_buffer_enable & PFS_DEF_WAKE_MASK[k]),
          "wake");
    end
    chk(8'(nmi_out), 8'(nm), "nmi");
  endtask : check_all

  task automatic check_cfgs();
    for (int k = 0; k < N; k++) begin
      @(posedge mclk_in);
      cfg_rd_idx_in <= 3'(k);
      step(2);
      #1;
      chk(8'(cfg_rdata_out), 8'(sh[k]), "cfg");
    end
  endtask : check_cfgs

  task automatic wr(input int k, input pfs_cfg_t c);
    @(posedge mclk_in);
    cfg_wr_in <= 1'b1;
    cfg_idx_in <= 3'(k);
    cfg_wdata_in <= c;
    @(posedge mclk_in);
    cfg_wr_in <= 1'b0;
    sh[k] = c;
  endtask : wr

  task automatic do_reset();
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    step(3);
    #1;
    chk(8'(pad_drive_out[1]), 8'h00, "rst drive");
    chk(8'(pad_speed_out[1]), 8'h00, "rst speed");
    for (int k = 0; k < N; k++) sh[k] = rst_cfg(k);
    @(posedge mclk_in);
    arst_n_in <= 1'b1;
  endtask : do_reset

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    int pk;
    void'($urandom(15040));
    do_reset();
    step(60);
    check_cfgs();
    step(6);
    check_all();
    // a write reaches the pad exactly one edge after the register
    wr(4, '{1'b0, 1'b0, 1'b1, PFS_SPD_SLOW, PFS_AF_0});
    #1;
    chk(8'(pad_drive_out[4].oe), 8'h00, "early");
    step(1);
    #1;
    chk(8'(pad_drive_out[4].oe), 8'h01, "late");
    wr(1, '{1'b0, 1'b0, 1'b1, PFS_SPD_MEDIUM, PFS_AF_0});
    step(6);
    check_all();
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk_in);
      func_in <= {$urandom, $urandom};
      boot_drive_in <= 16'($urandom);
      board_lvl <= 8'($urandom);
      boot_phase_in <= ($urandom % 4 == 0);
      pk = $urandom % N;
      wr(pk, rnd_cfg(pk));
      step(6);
      check_all();
      if (i == 200) do_reset();
    end
    check_cfgs();
    finish_test();
  end
endmodule : pfs_top_tb
`default_nettype wire
